// File: rtl/serial_flow_rx_irq.sv
// serial channel flow control, under-run, last-bit hold, rx interrupts
// assumes shifters, buffers and baud logic sit outside on i_clk_sys
//
// Summary of operation
// - external-clock shift mode: empty tx at next frame clock sets under-run
// - during under-run the data pin shows the selected level
// - internal-clock shift mode never raises the under-run flag
// - external-clock shift mode stretches the last bit by the hold setting
// - clear-to-send honoured only while flow control is enabled
// - clear-to-send high lets the current frame end, holds the next
// - tx interrupt and buffer fill continue while transmission is held
// - held frame starts on first tx bit clock fall (internal clock) or active serial clock edge (external clock) after clear-to-send low
// - single buffer: no rx irq in async modes, after last edge in shift
// - double buffer empty: rx irq when a frame enters the buffer
// - double buffer both full: rx irq when read moves waiting frame in
// - no rx irq for a frame that over-runs
// - fifo, condition 0: irq when level equals threshold on push or pop
// - fifo, condition 1: irq when a pop leaves level at or above threshold
// - under-run flagged just after the selected active serial clock edge
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "serial_flow_defs.svh"

module serial_flow_rx_irq (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  // register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // link pins
  input  wire logic       i_serial_clock_pin,
  input  wire logic       i_clear_to_send_in,
  output logic            o_tx_data_pin,
  // transmit side of the channel
  input  wire logic       i_tx_pending,
  input  wire logic       i_tx_bit_clk,
  input  wire logic       i_tx_shift_bit,
  input  wire logic       i_tx_frame_end,
  output logic            o_tx_start,
  // receive side of the channel
  input  wire logic       i_rx_frame_done,
  input  wire logic       i_rx_buf_read,
  output logic            o_rx_irq,
  output logic            o_rx_overrun,
  // interrupt
  output logic            o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and shared wires

  logic [5:0] ctrl_reg;
  logic [3:0] mode_reg;
  logic [2:0] rfc_reg;
  logic [1:0] istat_reg;
  logic [1:0] imask_reg;
  logic       underrun_flag_reg;
  logic [2:0] level_reg;
  logic       buf_full_reg;
  logic       shift_full_reg;
  logic       armed_reg;
  logic [3:0] bit_cnt_reg;
  logic [4:0] hold_cnt_reg;
  logic       last_bit_reg;
  logic       txclk_prev_reg;
  serial_flow_pkg::txf_state_t state_reg;

  link_sync_if lnk ();

  link_sampler u_link_sampler (
    .i_clk_sys          (i_clk_sys),
    .i_nrst             (i_nrst),
    .i_serial_clock_pin (i_serial_clock_pin),
    .i_clear_to_send_in (i_clear_to_send_in),
    .lnk                (lnk.producer)
  );

  function automatic logic thr_hit(input logic [2:0] lvl,
                                   input logic [1:0] thr,
                                   input logic       ge);
    thr_hit = ge ? (lvl >= {1'b0, thr}) : (lvl == {1'b0, thr});
  endfunction : thr_hit

  serial_flow_pkg::buf_cfg_t buf_cfg;
  logic       sio_mode;
  logic       ext_clk;
  logic       active_edge;
  logic       cts_block;
  logic       txclk_fall;
  logic       start_edge;
  logic       underrun_evt;

  assign buf_cfg  = serial_flow_pkg::buf_cfg_t'(
                      mode_reg[`MODE_BUF_MSB:`MODE_BUF_LSB]);
  assign sio_mode = mode_reg[`MODE_SIO_BIT];
  assign ext_clk  = sio_mode & ctrl_reg[`CTRL_EXTCLK_BIT];
  assign active_edge = ctrl_reg[`CTRL_EDGE_BIT] ? lnk.sclk_rise
                                                : lnk.sclk_fall;
  assign cts_block  = mode_reg[`MODE_CTS_BIT] & lnk.cts_level;
  assign txclk_fall = txclk_prev_reg & ~i_tx_bit_clk;
  // peer clock paces external mode, internal bit clock paces the rest
  assign start_edge = ext_clk ? active_edge : txclk_fall;

  ////////////////////////////////////////////////////////////////////////////
  // transmit flow: clear-to-send hold and under-run

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      txclk_prev_reg <= 1'b0;
    end else begin
      txclk_prev_reg <= i_tx_bit_clk;
    end
  end

  // the tx buffer keeps filling while held, only the start waits
  assign o_tx_start = (state_reg == serial_flow_pkg::TXF_WAIT) &
                      start_edge & ~cts_block;

  assign underrun_evt = (state_reg == serial_flow_pkg::TXF_IDLE) &
                        ext_clk & armed_reg & ~i_tx_pending &
                        active_edge;

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      state_reg   <= serial_flow_pkg::TXF_IDLE;
      bit_cnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        serial_flow_pkg::TXF_IDLE: begin
          if (underrun_evt) begin
            state_reg   <= serial_flow_pkg::TXF_UNDER;
            bit_cnt_reg <= 4'h1;
          end else if (i_tx_pending) begin
            state_reg <= serial_flow_pkg::TXF_WAIT;
          end
        end
        serial_flow_pkg::TXF_WAIT: begin
          if (o_tx_start) begin
            state_reg <= serial_flow_pkg::TXF_BUSY;
          end
        end
        serial_flow_pkg::TXF_BUSY: begin
          // a frame in flight always finishes, whatever the peer says
          if (i_tx_frame_end) begin
            state_reg <= serial_flow_pkg::TXF_IDLE;
          end
        end
        serial_flow_pkg::TXF_UNDER: begin
          if (!ext_clk) begin
            state_reg <= serial_flow_pkg::TXF_IDLE;
          end else if (active_edge) begin
            if (bit_cnt_reg == `FRAME_BITS) begin
              state_reg <= serial_flow_pkg::TXF_IDLE;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // armed only by a frame ending in external-clock mode
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      armed_reg <= 1'b0;
    end else if (o_tx_start | ~ext_clk) begin
      armed_reg <= 1'b0;
    end else if (i_tx_frame_end) begin
      armed_reg <= 1'b1;
    end
  end

  // set wins over the read clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      underrun_flag_reg <= 1'b0;
    end else if (underrun_evt) begin
      underrun_flag_reg <= 1'b1;
    end else if (i_rd && i_addr == `ADDR_CTRL) begin
      underrun_flag_reg <= 1'b0;
    end
  end

  // last-bit hold; the half-period bound is software's to keep
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      hold_cnt_reg <= 5'h00;
      last_bit_reg <= 1'b1;
    end else if (i_tx_frame_end && ext_clk) begin
      hold_cnt_reg <= 5'(ctrl_reg[`CTRL_HOLD_MSB:`CTRL_HOLD_LSB] *
                         `HOLD_STEP_CYC);
      last_bit_reg <= i_tx_shift_bit;
    end else if (hold_cnt_reg != 5'h00) begin
      hold_cnt_reg <= hold_cnt_reg - 5'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_tx_data_pin <= 1'b1;
    end else if (state_reg == serial_flow_pkg::TXF_UNDER) begin
      o_tx_data_pin <= ctrl_reg[`CTRL_LVL_BIT];
    end else if (state_reg == serial_flow_pkg::TXF_BUSY) begin
      o_tx_data_pin <= i_tx_shift_bit;
    end else if (hold_cnt_reg != 5'h00) begin
      o_tx_data_pin <= last_bit_reg;
    end else begin
      o_tx_data_pin <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive buffering and interrupt decision

  logic       fifo_mode;
  logic       single;
  logic       buf_leave;
  logic       buf_space;
  logic       move_sh;
  logic       direct;
  logic       to_shift;
  logic       overrun;
  logic       fifo_push;
  logic       fifo_pop;
  logic [2:0] level_next;
  logic       rx_evt;

  assign fifo_mode = (buf_cfg == serial_flow_pkg::BUF_FIFO);
  assign single    = (buf_cfg == serial_flow_pkg::BUF_SINGLE);
  assign fifo_push = fifo_mode & buf_full_reg & (level_reg < `FIFO_DEPTH);
  assign fifo_pop  = fifo_mode & i_rx_buf_read & (level_reg != 3'h0);
  assign buf_leave = fifo_mode ? fifo_push : (i_rx_buf_read & buf_full_reg);
  assign buf_space = ~buf_full_reg | buf_leave;
  assign move_sh   = shift_full_reg & buf_space;
  assign direct    = i_rx_frame_done & buf_space & ~shift_full_reg;
  assign overrun   = i_rx_frame_done & ~buf_space &
                     (single | shift_full_reg);
  assign to_shift  = i_rx_frame_done & ~direct & ~overrun;
  assign level_next = level_reg + {2'h0, fifo_push} - {2'h0, fifo_pop};

  always_comb begin
    rx_evt = 1'b0;
    unique case (buf_cfg)
      serial_flow_pkg::BUF_SINGLE: rx_evt = direct & sio_mode;
      serial_flow_pkg::BUF_DOUBLE: rx_evt = direct | move_sh;
      serial_flow_pkg::BUF_FIFO: begin
        if (rfc_reg[`RFC_COND_BIT]) begin
          rx_evt = fifo_pop &
                   thr_hit(level_next,
                           rfc_reg[`RFC_THR_MSB:`RFC_THR_LSB],
                           1'b1);
        end else begin
          rx_evt = (fifo_push | fifo_pop) &
                   thr_hit(level_next,
                           rfc_reg[`RFC_THR_MSB:`RFC_THR_LSB],
                           1'b0);
        end
      end
      default: rx_evt = 1'b0;
    endcase
  end

  // the over-running frame is dropped, and overrun masks the irq term in that cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      buf_full_reg   <= 1'b0;
      shift_full_reg <= 1'b0;
      level_reg      <= 3'h0;
      o_rx_irq       <= 1'b0;
      o_rx_overrun   <= 1'b0;
    end else begin
      buf_full_reg   <= (buf_full_reg & ~buf_leave) | move_sh | direct;
      shift_full_reg <= (shift_full_reg & ~move_sh) | to_shift;
      level_reg      <= level_next;
      o_rx_irq       <= rx_evt & ~overrun;
      o_rx_overrun   <= overrun;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port and interrupt output

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      ctrl_reg  <= `CTRL_RST;
      mode_reg  <= `MODE_RST;
      rfc_reg   <= `RFC_RST;
      imask_reg <= `IRQ_RST;
    end else if (i_wr) begin
      unique case (i_addr)
        `ADDR_CTRL:  ctrl_reg  <= i_wdata[5:0];
        `ADDR_MODE:  mode_reg  <= i_wdata[3:0];
        `ADDR_RFC:   rfc_reg   <= i_wdata[2:0];
        `ADDR_IMASK: imask_reg <= i_wdata[1:0];
        default: ;
      endcase
    end
  end

  // sticky events, write one to clear, new event wins
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      istat_reg <= `IRQ_RST;
    end else begin
      istat_reg[`IRQ_RX_BIT] <= o_rx_irq |
        (istat_reg[`IRQ_RX_BIT] &
         ~(i_wr & (i_addr == `ADDR_ISTAT) & i_wdata[`IRQ_RX_BIT]));
      istat_reg[`IRQ_UR_BIT] <= underrun_evt |
        (istat_reg[`IRQ_UR_BIT] &
         ~(i_wr & (i_addr == `ADDR_ISTAT) & i_wdata[`IRQ_UR_BIT]));
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        `ADDR_CTRL:  o_rdata <= {1'b0, underrun_flag_reg, ctrl_reg};
        `ADDR_MODE:  o_rdata <= {4'h0, mode_reg};
        `ADDR_RFC:   o_rdata <= {5'h00, rfc_reg};
        `ADDR_RST:   o_rdata <= {5'h00, level_reg};
        `ADDR_ISTAT: o_rdata <= {6'h00, istat_reg};
        `ADDR_IMASK: o_rdata <= {6'h00, imask_reg};
        default:     o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  assign o_irq = |(istat_reg & imask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_underrun_hit;
    underrun_evt;
  endsequence
  sequence s_flag_up;
    underrun_flag_reg && state_reg == serial_flow_pkg::TXF_UNDER;
  endsequence

  property p_underrun_flag;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      s_underrun_hit |=> s_flag_up;
  endproperty
  a_underrun_flag: assert property (p_underrun_flag)
    else $error("under-run not flagged");

  property p_underrun_level;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (state_reg == serial_flow_pkg::TXF_UNDER) [*2]
      |-> o_tx_data_pin == $past(ctrl_reg[`CTRL_LVL_BIT]);
  endproperty
  a_underrun_level: assert property (p_underrun_level)
    else $error("under-run pin level wrong");

  property p_no_flag_internal;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      $rose(underrun_flag_reg) |-> $past(ext_clk);
  endproperty
  a_no_flag_internal: assert property (p_no_flag_internal)
    else $error("under-run flagged without external clock");

  property p_hold_last;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (hold_cnt_reg != 5'h00 &&
       state_reg == serial_flow_pkg::TXF_IDLE && !underrun_evt)
      |=> o_tx_data_pin == $past(last_bit_reg);
  endproperty
  a_hold_last: assert property (p_hold_last)
    else $error("last bit not held");

  property p_cts_ignored;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (state_reg == serial_flow_pkg::TXF_WAIT && start_edge &&
       !mode_reg[`MODE_CTS_BIT]) |-> o_tx_start;
  endproperty
  a_cts_ignored: assert property (p_cts_ignored)
    else $error("start blocked while flow control off");

  property p_cts_hold;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      cts_block |-> !o_tx_start;
  endproperty
  a_cts_hold: assert property (p_cts_hold)
    else $error("frame started while held");

  property p_start_edge;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (o_tx_start && !ext_clk) |-> $past(i_tx_bit_clk) && !i_tx_bit_clk;
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("start not on tx bit clock fall");

  property p_overrun_quiet;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      overrun |=> !o_rx_irq;
  endproperty
  a_overrun_quiet: assert property (p_overrun_quiet)
    else $error("rx irq on over-run");

  property p_irq_pulse;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      o_rx_irq |=> !o_rx_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("rx irq longer than one cycle");

  property p_fifo_eq;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (fifo_mode && !rfc_reg[`RFC_COND_BIT] && fifo_push && !fifo_pop &&
       level_next == {1'b0, rfc_reg[`RFC_THR_MSB:`RFC_THR_LSB]} && !overrun)
      |=> o_rx_irq && level_reg == $past(level_next);
  endproperty
  a_fifo_eq: assert property (p_fifo_eq)
    else $error("fifo threshold irq missing");

endmodule : serial_flow_rx_irq

`default_nettype wire

// File: include/serial_flow_defs.svh
// constants for the serial flow control and receive interrupt block
// assumes an 8-bit register port with 4-bit word addresses
`ifndef SERIAL_FLOW_DEFS_SVH
`define SERIAL_FLOW_DEFS_SVH

// register addresses
`define ADDR_CTRL        4'h0
`define ADDR_MODE        4'h1
`define ADDR_RFC         4'h2
`define ADDR_RST         4'h3
`define ADDR_ISTAT       4'h4
`define ADDR_IMASK       4'h5

// serial_control_reg fields
`define CTRL_LVL_BIT     0
`define CTRL_HOLD_LSB    1
`define CTRL_HOLD_MSB    3
`define CTRL_EDGE_BIT    4
`define CTRL_EXTCLK_BIT  5
`define CTRL_WR_MASK     8'h3f

// serial_mode_reg0 fields
`define MODE_CTS_BIT     0
`define MODE_BUF_LSB     1
`define MODE_BUF_MSB     2
`define MODE_SIO_BIT     3

// rx_fifo_ctrl_reg fields
`define RFC_THR_LSB      0
`define RFC_THR_MSB      1
`define RFC_COND_BIT     2

// interrupt status and mask bits
`define IRQ_RX_BIT       0
`define IRQ_UR_BIT       1

// reset values
`define CTRL_RST         6'h00
`define MODE_RST         4'h0
`define RFC_RST          3'h0
`define IRQ_RST          2'h0
`define SCLK_SYNC_RST    2'h3
`define SCLK_PREV_RST    1'b1

// sizes and timing
`define FIFO_DEPTH       3'h4
`define FRAME_BITS       4'h8
`define CLK_PERIOD_NS    20
`define HOLD_STEP_NS     40
`define HOLD_STEP_CYC    ((`HOLD_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: include/serial_flow_pkg.sv
// types shared by the serial flow control block
// assumes the constants header is included by the design files
package serial_flow_pkg;

  typedef enum logic [1:0] {
    BUF_SINGLE = 2'b00,
    BUF_DOUBLE = 2'b01,
    BUF_FIFO   = 2'b10
  } buf_cfg_t;

  typedef enum logic [1:0] {
    TXF_IDLE  = 2'b00,
    TXF_WAIT  = 2'b01,
    TXF_BUSY  = 2'b10,
    TXF_UNDER = 2'b11
  } txf_state_t;

endpackage : serial_flow_pkg

// File: include/link_sync_if.sv
// synchronised serial clock and clear-to-send, with serial clock edges
// assumes producer and consumer share i_clk_sys
`timescale 1ns/1ns
`default_nettype none

interface link_sync_if;
  logic sclk_rise;
  logic sclk_fall;
  logic cts_level;

  modport producer (
    output sclk_rise,
    output sclk_fall,
    output cts_level
  );
  modport consumer (
    input  sclk_rise,
    input  sclk_fall,
    input  cts_level
  );
endinterface : link_sync_if

`default_nettype wire

// File: rtl/link_sampler.sv
// two-flop synchronisers and edge finder for the link pins
// assumes pins are asynchronous to i_clk_sys and slower than it
`timescale 1ns/1ns
`default_nettype none
`include "serial_flow_defs.svh"

module link_sampler (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  // pins
  input  wire logic       i_serial_clock_pin,
  input  wire logic       i_clear_to_send_in,
  // synchronised view
  link_sync_if.producer   lnk
);

  logic [1:0] sclk_sync_reg;
  logic       sclk_prev_reg;
  logic [1:0] cts_sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      // idle-high clock: no false edge once reset lets go
      sclk_sync_reg <= `SCLK_SYNC_RST;
      sclk_prev_reg <= `SCLK_PREV_RST;
      cts_sync_reg  <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], i_serial_clock_pin};
      sclk_prev_reg <= sclk_sync_reg[1];
      cts_sync_reg  <= {cts_sync_reg[0], i_clear_to_send_in};
    end
  end

  assign lnk.sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign lnk.sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg;
  assign lnk.cts_level = cts_sync_reg[1];

endmodule : link_sampler

`default_nettype wire

// File: tb/serial_peer.sv
// remote serial peer: serial clock and clear-to-send
// assumes the bench calls its tasks; clock stands high between frames
`timescale 1ns/1ns
`default_nettype none

module serial_peer (
  // link pins
  output var logic o_sclk,
  output var logic o_cts
);
  initial begin
    o_sclk = 1'b1;
    o_cts  = 1'b0;
  end

  // 160 ns period; bench keeps the hold setting within half of it
  task automatic frame(input int n);
    #7;
    repeat (n) begin
      #80 o_sclk = 1'b0;
      #80 o_sclk = 1'b1;
    end
  endtask : frame

  // high asks the block to hold its next frame
  task automatic set_cts(input logic v);
    o_cts = v;
  endtask : set_cts
endmodule : serial_peer

`default_nettype wire

// File: tb/tb.sv
// self-checking bench for serial_flow_rx_irq
// assumes 50 MHz clock, peer model in serial_peer.sv
`timescale 1ns/1ns
`default_nettype none
`include "serial_flow_defs.svh"

module tb;
  logic       clk, nrst, wr, rd, sclk, cts, txd, pend, bclk, bclk_q;
  logic       sbit, fend, start, rxdone, rxread, rxirq, ovr, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [2:0] div;
  logic       hb;
  int         err_total, n_checks, n_irq, n_ovr, n_start;

  serial_flow_rx_irq dut_u (
    .i_clk_sys(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_serial_clock_pin(sclk),
    .i_clear_to_send_in(cts), .o_tx_data_pin(txd), .i_tx_pending(pend),
    .i_tx_bit_clk(bclk), .i_tx_shift_bit(sbit), .i_tx_frame_end(fend),
    .o_tx_start(start), .i_rx_frame_done(rxdone), .i_rx_buf_read(rxread),
    .o_rx_irq(rxirq), .o_rx_overrun(ovr), .o_irq(irq)
  );
  serial_peer peer_u (.o_sclk(sclk), .o_cts(cts));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // free bit clock and random shifter bits; pulse counters
  always @(posedge clk) begin
    div    <= div + 3'h1;
    bclk   <= div[2];
    bclk_q <= bclk;
    sbit   <= 1'($urandom);
    n_irq   += int'(rxirq === 1'b1);
    n_ovr   += int'(ovr === 1'b1);
    n_start += int'(start === 1'b1);
  end

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(negedge clk);
  endtask : wrr

  task automatic rdr(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk("read data", rdata, exp);
  endtask : rdr

  // one frame arrival or one buffer read, random gap after
  task automatic rx_ev(input logic pop);
    @(posedge clk);
    rxdone <= ~pop;
    rxread <= pop;
    @(posedge clk);
    rxdone <= 1'b0;
    rxread <= 1'b0;
    repeat (3 + $urandom % 6) @(posedge clk);
  endtask : rx_ev

  task automatic rx_cnt(input int exp);
    chk("rx irq pulses", 8'(n_irq), 8'(exp));
    n_irq = 0;
  endtask : rx_cnt

  // raise pending, wait for a start, then finish the frame
  task automatic go_tx(input logic on_bclk);
    int k;
    k = 0;
    @(posedge clk);
    pend <= 1'b1;
    while (start !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    if (on_bclk) chk("start edge", {6'h00, bclk_q, bclk}, 8'h02);
    chk("tx started", 8'(k < 400), 8'h01);
    @(posedge clk);
    pend <= 1'b0;
    repeat (4) @(posedge clk);
    fend <= 1'b1;
    @(posedge clk);
    fend <= 1'b0;
    // last bit as the shifter showed it at frame end
    hb = sbit;
  endtask : go_tx

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hfbf3f36f));
    {nrst, wr, rd, pend, fend, rxdone, rxread, sbit, bclk} = '0;
    {addr, wdata, div, bclk_q} = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk("idle pin", {7'h00, txd}, 8'h01);
    for (int a = 0; a < 7; a++) rdr((a == 6) ? 4'hf : 4'(a), 8'h00);
    wrr(`ADDR_CTRL, 8'hff);
    rdr(`ADDR_CTRL, 8'h3f);
    wrr(`ADDR_CTRL, 8'h00);
    $display("test registers done");
    // double buffer: fill, over-run, drain
    wrr(`ADDR_MODE, 8'h02);
    n_irq = 0;
    rx_ev(1'b0);
    rx_cnt(1);
    rx_ev(1'b0);
    rx_ev(1'b0);
    rx_cnt(0);
    chk("overruns", 8'(n_ovr), 8'h01);
    rx_ev(1'b1);
    rx_cnt(1);
    rx_ev(1'b1);
    rx_cnt(0);
    // single buffer: async silent whatever arrives, shift mode fires
    wrr(`ADDR_MODE, 8'h00);
    repeat (4) rx_ev(1'($urandom));
    rx_cnt(0);
    rx_ev(1'b1);
    wrr(`ADDR_MODE, 8'h08);
    rx_ev(1'b0);
    rx_cnt(1);
    rx_ev(1'b1);
    $display("test buffers done");
    // fifo, threshold 2 condition 0, then threshold 1 condition 1
    wrr(`ADDR_RFC, 8'h02);
    wrr(`ADDR_MODE, 8'h04);
    n_irq = 0;
    repeat (3) rx_ev(1'b0);
    rx_cnt(1);
    rdr(`ADDR_RST, 8'h03);
    rx_ev(1'b1);
    rx_cnt(1);
    wrr(`ADDR_RFC, 8'h05);
    rx_ev(1'b1);
    rx_ev(1'b1);
    rx_cnt(1);
    chk("masked irq", {7'h00, irq}, 8'h00);
    wrr(`ADDR_IMASK, 8'h01);
    chk("rx irq level", {7'h00, irq}, 8'h01);
    wrr(`ADDR_ISTAT, 8'h01);
    rdr(`ADDR_ISTAT, 8'h00);
    $display("test fifo done");
    // flow control held, released, then ignored when disabled
    wrr(`ADDR_MODE, 8'h01);
    peer_u.set_cts(1'b1);
    n_start = 0;
    fork
      go_tx(1'b1);
      begin
        repeat (40) @(posedge clk);
        chk("held starts", 8'(n_start), 8'h00);
        peer_u.set_cts(1'b0);
      end
    join
    chk("starts", 8'(n_start), 8'h01);
    wrr(`ADDR_MODE, 8'h00);
    peer_u.set_cts(1'b1);
    go_tx(1'b1);
    peer_u.set_cts(1'($urandom));
    go_tx(1'b1);
    peer_u.set_cts(1'b0);
    $display("test flow done");
    // external clock under-run at both pin levels
    wrr(`ADDR_MODE, 8'h08);
    wrr(`ADDR_IMASK, 8'h02);
    // hold code 2: 80 ns, half the peer's clock period
    wrr(`ADDR_CTRL, 8'h24);
    fork
      go_tx(1'b0);
      peer_u.frame(1);
    join
    repeat (2) @(negedge clk);
    chk("held bit", {7'h00, txd}, {7'h00, hb});
    repeat (4) @(negedge clk);
    chk("hold over", {7'h00, txd}, 8'h01);
    for (int l = 0; l < 2; l++) begin
      wrr(`ADDR_CTRL, 8'h20 | 8'(l));
      fork
        peer_u.frame(8);
        #500 chk("underrun pin", {7'h00, txd}, 8'(l));
      join
      rdr(`ADDR_CTRL, 8'h60 | 8'(l));
      rdr(`ADDR_CTRL, 8'h20 | 8'(l));
      chk("underrun irq", {7'h00, irq}, 8'h01);
      wrr(`ADDR_ISTAT, 8'h02);
      chk("irq cleared", {7'h00, irq}, 8'h00);
    end
    // internal clock: serial edges never flag
    wrr(`ADDR_CTRL, 8'h00);
    peer_u.frame(8);
    rdr(`ADDR_CTRL, 8'h00);
    $display("test underrun done");
    end_sim();
  end
endmodule : tb

`default_nettype wire
